//--- common/rss_defs.svh
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// register byte addresses, one aligned word each
`define RSS_OFS_CMD 8'h00
`define RSS_OFS_MEMOP 8'h04
`define RSS_OFS_IMM 8'h08
`define RSS_OFS_WREG 8'h0C
`define RSS_OFS_FLAGS 8'h10
`define RSS_OFS_MEMRES 8'h14
`define RSS_OFS_STATUS 8'h18

// command word fields
`define RSS_CMD_OP_LSB 0
`define RSS_CMD_OP_MSB 4
`define RSS_CMD_BIT_LSB 8
`define RSS_CMD_BIT_MSB 10

// status word fields
`define RSS_STS_BUSY 0
`define RSS_STS_SKIP 1
`define RSS_STS_MEMWR 2
`define RSS_STS_CYC_LSB 4
`define RSS_STS_CYC_MSB 5

// instruction cycles with and without a taken skip
`define RSS_CYC_PLAIN 2'h1
`define RSS_CYC_SKIP 2'h2

`define RSS_BYTE_ONES 8'hFF
`define RSS_BYTE_ONE 8'h01
`define RSS_BYTE_ZERO 8'h00
`define RSS_FLAGS_RST 6'h00

`endif

//--- common/rss_pkg.sv
package rss_pkg;

    typedef enum logic [4:0] {
        OP_ROTATE_LEFT_MEM,
        OP_ROTATE_LEFT_TO_WREG,
        OP_ROTATE_LEFT_THRU_FLAG,
        OP_ROTATE_LEFT_THRU_FLAG_TO_WREG,
        OP_ROTATE_RIGHT_MEM,
        OP_ROTATE_RIGHT_TO_WREG,
        OP_ROTATE_RIGHT_THRU_FLAG,
        OP_ROTATE_RIGHT_THRU_FLAG_TO_WREG,
        OP_SUBTRACT_WITH_BORROW,
        OP_SUBTRACT_WITH_BORROW_IMM,
        OP_BORROW_MINUS_INTO_MEM,
        OP_SUBTRACT,
        OP_SUBTRACT_IMM,
        OP_MINUS_INTO_MEM,
        OP_DECREMENT_SKIP_IF_NULL,
        OP_DECREMENT_SKIP_TO_WREG,
        OP_INCREMENT_SKIP_IF_NULL,
        OP_INCREMENT_SKIP_TO_WREG,
        OP_SET_BYTE,
        OP_SET_BIT,
        OP_SKIP_IF_NONNULL,
        OP_SKIP_IF_NONNULL_BIT
    } rss_op_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_DUMMY
    } rss_st_type;

    typedef struct packed {
        logic chainedNull;
        logic signedCarry;
        logic carry;
        logic halfCarry;
        logic zero;
        logic signedWrap;
    } rss_flags_type;

    typedef struct packed {
        rss_st_type st;
        logic [4:0] op;
        logic [2:0] bitSel;
        logic [7:0] memOp;
        logic [7:0] imm;
        logic [7:0] wreg;
        rss_flags_type flags;
        logic [7:0] memRes;
        logic memWrEn;
        logic skipNext;
        logic skipTaken;
        logic memWritten;
        logic dpValid;
        logic dpWrite;
        logic [7:0] dpAddr;
        logic rdReady;
        logic [31:0] hrdata;
    } rss_state_type;

endpackage : rss_pkg

//--- logic/rss_alu.sv
`timescale 1ns/1ps
`include "rss_defs.svh"
// Behaviour
// (RULE_01) rotate memory left, bit 7 to 0
// (RULE_02) rotate left into working register only
// (RULE_03) rotate left through carry, write back
// (RULE_04) rotate left through carry into wreg
// (RULE_05) rotate memory right, bit 0 to 7
// (RULE_06) rotate right into working register only
// (RULE_07) rotate right through carry, write back
// (RULE_08) rotate right through carry into wreg
// (RULE_09) wreg minus memory minus inverted carry
// (RULE_10) carry clear when negative, else set
// (RULE_11) borrow subtract with immediate operand
// (RULE_12) borrow subtract result into memory
// (RULE_13) decrement memory, skip on zero
// (RULE_14) taken skip costs a dummy cycle
// (RULE_15) decrement into wreg, skip on zero
// (RULE_16) set whole memory byte to ones
// (RULE_17) set one selected memory bit
// (RULE_18) increment memory, skip on zero
// (RULE_19) increment into wreg, skip on zero
// (RULE_20) skip when byte or bit nonzero
// (RULE_21) plain subtract, wreg or memory target
module rss_alu (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic memWrEn,
    output logic [7:0] memWrData,
    output logic skipNext,
    output logic dummyCycle
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rstSync_reg;
    logic rstN;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rstSync_reg <= 2'h0;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end
    assign rstN = rstSync_reg[1];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rss_pkg::rss_state_type s_reg;
    rss_pkg::rss_state_type s_next;

    logic idle;
    logic [7:0] m;
    logic [7:0] b;
    logic bin;
    logic [8:0] diff;
    logic [4:0] nib;
    logic [7:0] res;
    logic [7:0] bitMask;
    logic [31:0] rdVal;

    assign idle = (s_reg.st == rss_pkg::ST_IDLE);
    assign m = s_reg.memOp;
    assign bitMask = 8'h01 << s_reg.bitSel;

    // shared subtractor; immediate forms take imm, the rest memory
    always_comb begin
        b = m;
        bin = 1'b0;
        case (rss_pkg::rss_op_type'(s_reg.op))
            rss_pkg::OP_SUBTRACT_WITH_BORROW_IMM: begin
                b = s_reg.imm;
                bin = ~s_reg.flags.carry; // see (RULE_11)
            end
            rss_pkg::OP_SUBTRACT_WITH_BORROW,
            rss_pkg::OP_BORROW_MINUS_INTO_MEM: begin
                bin = ~s_reg.flags.carry; // see (RULE_09)
            end
            rss_pkg::OP_SUBTRACT_IMM: begin
                b = s_reg.imm; // see (RULE_21)
            end
            default: begin
                b = m;
            end
        endcase
        diff = {1'b0, s_reg.wreg} - {1'b0, b} - {8'h00, bin};
        nib = {1'b0, s_reg.wreg[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
        res = diff[7:0];
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rdVal = 32'h0000_0000;
        if (s_reg.dpAddr == `RSS_OFS_CMD) begin
            rdVal[`RSS_CMD_OP_MSB:`RSS_CMD_OP_LSB] = s_reg.op;
            rdVal[`RSS_CMD_BIT_MSB:`RSS_CMD_BIT_LSB] = s_reg.bitSel;
        end else if (s_reg.dpAddr == `RSS_OFS_MEMOP) begin
            rdVal[7:0] = s_reg.memOp;
        end else if (s_reg.dpAddr == `RSS_OFS_IMM) begin
            rdVal[7:0] = s_reg.imm;
        end else if (s_reg.dpAddr == `RSS_OFS_WREG) begin
            rdVal[7:0] = s_reg.wreg;
        end else if (s_reg.dpAddr == `RSS_OFS_FLAGS) begin
            rdVal[5:0] = s_reg.flags;
        end else if (s_reg.dpAddr == `RSS_OFS_MEMRES) begin
            rdVal[7:0] = s_reg.memRes;
        end else if (s_reg.dpAddr == `RSS_OFS_STATUS) begin
            rdVal[`RSS_STS_BUSY] = ~idle;
            rdVal[`RSS_STS_SKIP] = s_reg.skipTaken;
            rdVal[`RSS_STS_MEMWR] = s_reg.memWritten;
            rdVal[`RSS_STS_CYC_MSB:`RSS_STS_CYC_LSB] =
                s_reg.skipTaken ? `RSS_CYC_SKIP : `RSS_CYC_PLAIN;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic wr;
        logic toMem;
        logic toW;
        logic sub;
        logic skip;
        logic [7:0] r;
        wr = 1'b0;
        toMem = 1'b0;
        toW = 1'b0;
        sub = 1'b0;
        skip = 1'b0;
        r = m;
        s_next = s_reg;
        s_next.memWrEn = 1'b0;
        s_next.skipNext = 1'b0;

        // bus address phase; busy stalls writes so no command is lost
        if (hreadyout) begin
            s_next.dpValid = hsel & htrans[1] & hready;
            s_next.dpWrite = hwrite;
            s_next.dpAddr = {haddr[7:2], 2'b00};
            s_next.rdReady = 1'b0;
        end
        if (s_reg.dpValid && !s_reg.dpWrite && !s_reg.rdReady && idle) begin
            s_next.rdReady = 1'b1;
            s_next.hrdata = rdVal;
        end
        wr = s_reg.dpValid & s_reg.dpWrite & idle;
        if (wr) begin
            if (s_reg.dpAddr == `RSS_OFS_CMD) begin
                s_next.op = hwdata[`RSS_CMD_OP_MSB:`RSS_CMD_OP_LSB];
                s_next.bitSel = hwdata[`RSS_CMD_BIT_MSB:`RSS_CMD_BIT_LSB];
                s_next.st = rss_pkg::ST_EXEC;
            end else if (s_reg.dpAddr == `RSS_OFS_MEMOP) begin
                s_next.memOp = hwdata[7:0];
            end else if (s_reg.dpAddr == `RSS_OFS_IMM) begin
                s_next.imm = hwdata[7:0];
            end else if (s_reg.dpAddr == `RSS_OFS_WREG) begin
                s_next.wreg = hwdata[7:0];
            end else if (s_reg.dpAddr == `RSS_OFS_FLAGS) begin
                s_next.flags = hwdata[5:0];
            end
        end

        case (s_reg.st)
            rss_pkg::ST_EXEC: begin
                case (rss_pkg::rss_op_type'(s_reg.op))
                    rss_pkg::OP_ROTATE_LEFT_MEM: begin
                        r = {m[6:0], m[7]}; // see (RULE_01)
                        toMem = 1'b1;
                    end
                    rss_pkg::OP_ROTATE_LEFT_TO_WREG: begin
                        r = {m[6:0], m[7]}; // see (RULE_02)
                        toW = 1'b1;
                    end
                    rss_pkg::OP_ROTATE_LEFT_THRU_FLAG: begin
                        r = {m[6:0], s_reg.flags.carry}; // see (RULE_03)
                        s_next.flags.carry = m[7];
                        toMem = 1'b1;
                    end
                    rss_pkg::OP_ROTATE_LEFT_THRU_FLAG_TO_WREG: begin
                        r = {m[6:0], s_reg.flags.carry}; // see (RULE_04)
                        s_next.flags.carry = m[7];
                        toW = 1'b1;
                    end
                    rss_pkg::OP_ROTATE_RIGHT_MEM: begin
                        r = {m[0], m[7:1]}; // see (RULE_05)
                        toMem = 1'b1;
                    end
                    rss_pkg::OP_ROTATE_RIGHT_TO_WREG: begin
                        r = {m[0], m[7:1]}; // see (RULE_06)
                        toW = 1'b1;
                    end
                    rss_pkg::OP_ROTATE_RIGHT_THRU_FLAG: begin
                        r = {s_reg.flags.carry, m[7:1]}; // see (RULE_07)
                        s_next.flags.carry = m[0];
                        toMem = 1'b1;
                    end
                    rss_pkg::OP_ROTATE_RIGHT_THRU_FLAG_TO_WREG: begin
                        r = {s_reg.flags.carry, m[7:1]}; // see (RULE_08)
                        s_next.flags.carry = m[0];
                        toW = 1'b1;
                    end
                    rss_pkg::OP_SUBTRACT_WITH_BORROW,
                    rss_pkg::OP_SUBTRACT_WITH_BORROW_IMM,
                    rss_pkg::OP_SUBTRACT,
                    rss_pkg::OP_SUBTRACT_IMM: begin
                        r = res; // see (RULE_09) (RULE_11) (RULE_21)
                        sub = 1'b1;
                        toW = 1'b1;
                    end
                    rss_pkg::OP_BORROW_MINUS_INTO_MEM,
                    rss_pkg::OP_MINUS_INTO_MEM: begin
                        r = res; // see (RULE_12) (RULE_21)
                        sub = 1'b1;
                        toMem = 1'b1;
                    end
                    rss_pkg::OP_DECREMENT_SKIP_IF_NULL: begin
                        r = m - `RSS_BYTE_ONE; // see (RULE_13)
                        skip = (r == `RSS_BYTE_ZERO);
                        toMem = 1'b1;
                    end
                    rss_pkg::OP_DECREMENT_SKIP_TO_WREG: begin
                        r = m - `RSS_BYTE_ONE; // see (RULE_15)
                        skip = (r == `RSS_BYTE_ZERO);
                        toW = 1'b1;
                    end
                    rss_pkg::OP_INCREMENT_SKIP_IF_NULL: begin
                        r = m + `RSS_BYTE_ONE; // see (RULE_18)
                        skip = (r == `RSS_BYTE_ZERO);
                        toMem = 1'b1;
                    end
                    rss_pkg::OP_INCREMENT_SKIP_TO_WREG: begin
                        r = m + `RSS_BYTE_ONE; // see (RULE_19)
                        skip = (r == `RSS_BYTE_ZERO);
                        toW = 1'b1;
                    end
                    rss_pkg::OP_SET_BYTE: begin
                        r = `RSS_BYTE_ONES; // see (RULE_16)
                        toMem = 1'b1;
                    end
                    rss_pkg::OP_SET_BIT: begin
                        r = m | bitMask; // see (RULE_17)
                        toMem = 1'b1;
                    end
                    rss_pkg::OP_SKIP_IF_NONNULL: begin
                        skip = (m != `RSS_BYTE_ZERO); // see (RULE_20)
                    end
                    rss_pkg::OP_SKIP_IF_NONNULL_BIT: begin
                        skip = ((m & bitMask) != `RSS_BYTE_ZERO); // see (RULE_20)
                    end
                    default: begin
                        skip = 1'b0;
                    end
                endcase
                if (sub) begin
                    s_next.flags.carry = ~diff[8]; // see (RULE_10)
                    s_next.flags.halfCarry = ~nib[4];
                    s_next.flags.zero = (res == `RSS_BYTE_ZERO);
                    s_next.flags.signedWrap = (s_reg.wreg[7] != b[7]) &&
                        (res[7] != s_reg.wreg[7]);
                    s_next.flags.signedCarry = res[7] ^ s_next.flags.signedWrap;
                    // chained zero keeps multi-byte zero across borrow chains
                    s_next.flags.chainedNull = (res == `RSS_BYTE_ZERO) &&
                        ((s_reg.op >= rss_pkg::OP_SUBTRACT) || s_reg.flags.chainedNull);
                end
                if (toW) begin
                    s_next.wreg = r;
                end
                s_next.memWrEn = toMem;
                s_next.memWritten = toMem;
                if (toMem) begin
                    s_next.memRes = r;
                    s_next.memOp = r;
                end
                s_next.skipNext = skip;
                s_next.skipTaken = skip;
                s_next.st = skip ? rss_pkg::ST_DUMMY : rss_pkg::ST_IDLE; // see (RULE_14)
            end
            rss_pkg::ST_DUMMY: begin
                s_next.st = rss_pkg::ST_IDLE;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            s_reg <= '{st: rss_pkg::ST_IDLE, flags: `RSS_FLAGS_RST, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // reads wait one cycle so hrdata comes from a flop
    assign hreadyout = !s_reg.dpValid || (s_reg.dpWrite ? idle : s_reg.rdReady);
    assign hresp = 1'b0;
    assign hrdata = s_reg.hrdata;
    assign memWrEn = s_reg.memWrEn;
    assign memWrData = s_reg.memRes;
    assign skipNext = s_reg.skipNext;
    assign dummyCycle = (s_reg.st == rss_pkg::ST_DUMMY);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstN);

    logic ex;
    logic [4:0] xop;
    assign ex = (s_reg.st == rss_pkg::ST_EXEC);
    assign xop = s_reg.op;

    rot_left_mem_a: assert property (ex && xop == rss_pkg::OP_ROTATE_LEFT_MEM |=> // see (RULE_01)
        memWrEn && memWrData == {$past(m[6:0]), $past(m[7])})
        else $error("rotate left to memory wrong");
    rot_left_w_a: assert property (ex && xop == rss_pkg::OP_ROTATE_LEFT_TO_WREG |=> // see (RULE_02)
        !memWrEn && s_reg.wreg == {$past(m[6:0]), $past(m[7])} && m == $past(m))
        else $error("rotate left to wreg wrong");
    rot_lc_a: assert property (ex && xop == rss_pkg::OP_ROTATE_LEFT_THRU_FLAG |=> // see (RULE_03)
        memWrData[0] == $past(s_reg.flags.carry) && s_reg.flags.carry == $past(m[7]))
        else $error("rotate left through carry wrong");
    rot_rc_w_a: assert property (ex && xop == rss_pkg::OP_ROTATE_RIGHT_THRU_FLAG_TO_WREG |=> // see (RULE_08)
        s_reg.wreg[7] == $past(s_reg.flags.carry) && s_reg.flags.carry == $past(m[0]))
        else $error("rotate right through carry wrong");
    rot_right_mem_a: assert property (ex && xop == rss_pkg::OP_ROTATE_RIGHT_MEM |=> // see (RULE_05)
        memWrData == {$past(m[0]), $past(m[7:1])} && s_reg.flags == $past(s_reg.flags))
        else $error("rotate right to memory wrong");
    sub_carry_a: assert property (ex && xop == rss_pkg::OP_SUBTRACT |=> // see (RULE_10)
        s_reg.flags.carry == ($past(s_reg.wreg) >= $past(m)))
        else $error("subtract carry wrong");
    sbc_value_a: assert property (ex && xop == rss_pkg::OP_SUBTRACT_WITH_BORROW |=> // see (RULE_09)
        s_reg.wreg == 8'($past(s_reg.wreg) - $past(m) - {7'h00, ~$past(s_reg.flags.carry)}))
        else $error("subtract with borrow wrong");
    dec_skip_a: assert property (ex && xop == rss_pkg::OP_DECREMENT_SKIP_IF_NULL |=> // see (RULE_13)
        memWrEn && (skipNext == (memWrData == 8'h00)))
        else $error("decrement skip wrong");
    skip_dummy_a: assert property (skipNext |-> dummyCycle ##1 !dummyCycle) // see (RULE_14)
        else $error("skip dummy cycle wrong");
    set_bit_a: assert property (ex && xop == rss_pkg::OP_SET_BIT |=> // see (RULE_17)
        memWrData == ($past(m) | (8'h01 << $past(s_reg.bitSel))))
        else $error("set bit wrong");
    nz_skip_a: assert property (ex && xop == rss_pkg::OP_SKIP_IF_NONNULL |=> // see (RULE_20)
        skipNext == ($past(m) != 8'h00) && !memWrEn)
        else $error("skip nonzero wrong");

    skip_seen_c: cover property (skipNext && dummyCycle ##1 !dummyCycle);
    sub_neg_c: cover property (ex && xop == rss_pkg::OP_SUBTRACT ##1 !s_reg.flags.carry);
    rd_wait_c: cover property (s_reg.dpValid && !s_reg.dpWrite ##1 hreadyout);

endmodule : rss_alu

//--- tb/rss_mem_seq_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// data memory and sequencer stand-in
// ------------------------------------------------------------
module rss_mem_seq_model (
    input wire logic clk_sys,
    input wire logic memWrEn,
    input wire logic [7:0] memWrData,
    input wire logic skipNext,
    input wire logic dummyCycle,
    output logic [7:0] memByte,
    output int wrCount,
    output int skipCount,
    output int dummyCount,
    output int pairErr
);

    initial begin
        memByte = 8'h00;
        wrCount = 0;
        skipCount = 0;
        dummyCount = 0;
        pairErr = 0;
    end

    // pulses are one cycle wide, so every edge must be looked at
    always @(posedge clk_sys) begin
        if (memWrEn === 1'b1) begin
            memByte <= memWrData;
            wrCount <= wrCount + 1;
        end
        if (skipNext === 1'b1) begin
            skipCount <= skipCount + 1;
        end
        if (dummyCycle === 1'b1) begin
            dummyCount <= dummyCount + 1;
        end
        // the dummy cycle is the skip's second cycle, shown beside the skip pulse
        if ((dummyCycle === 1'b1) != (skipNext === 1'b1)) begin
            pairErr <= pairErr + 1;
        end
    end
endmodule : rss_mem_seq_model

//--- tb/rotate_subtract_skip_alu_tb_top.sv
`timescale 1ns/1ps
`include "rss_defs.svh"
module rotate_subtract_skip_alu_tb_top;
    logic clk_sys, arst_n, hsel, hwrite, hreadyout, hresp, memWrEn, skipNext, dummyCycle;
    logic rdPend;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] memWrData, memByte, lastRes;
    int wrCount, skipCount, dummyCount, pairErr, failures, n_compared, i;
    integer seed;
    logic [31:0] expQ[$];
    string nameQ[$];

    rss_alu i_rss_alu (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .memWrEn(memWrEn),
        .memWrData(memWrData), .skipNext(skipNext), .dummyCycle(dummyCycle));

    rss_mem_seq_model i_rss_mem_seq_model (.clk_sys(clk_sys), .memWrEn(memWrEn),
        .memWrData(memWrData), .skipNext(skipNext), .dummyCycle(dummyCycle),
        .memByte(memByte), .wrCount(wrCount), .skipCount(skipCount),
        .dummyCount(dummyCount), .pairErr(pairErr));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task conclude;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // read data is taken at the edge that ends the data phase
    always @(posedge clk_sys) begin
        if (rdPend === 1'b1 && hreadyout === 1'b1) begin
            check(nameQ.pop_front(), hrdata, expQ.pop_front());
            check("bus response", {31'h0, hresp}, 32'h0);
        end
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        failures++;
        $display("MISMATCH watchdog expected finish seen timeout");
        conclude();
    end

    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do begin
            @(posedge clk_sys);
        end while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        rdPend <= ~wr;
        do begin
            @(posedge clk_sys);
        end while (hreadyout !== 1'b1);
        rdPend <= 1'b0;
    endtask : ahb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        expQ.push_back(exp);
        nameQ.push_back(what);
        ahb(1'b0, a, 32'h0);
    endtask : rd

    // ------------------------------------------------------------
    // one instruction with expected results
    // ------------------------------------------------------------
    task automatic run_op(input logic [4:0] op, input logic [7:0] m, input logic [7:0] im,
            input logic [7:0] w, input logic [5:0] f, input logic [2:0] b);
        logic [7:0] ew, em, r, sb;
        logic [5:0] ef;
        logic [8:0] d;
        logic [4:0] h;
        logic sk, mw, bi, ov;
        int w0, s0, d0;
        ew = w;
        em = m;
        ef = f;
        sk = 1'b0;
        mw = 1'b0;
        sb = (op == 5'd9 || op == 5'd12) ? im : m;
        bi = (op >= 5'd8 && op <= 5'd10) ? ~f[3] : 1'b0;
        d = {1'b0, w} - {1'b0, sb} - {8'h0, bi};
        h = {1'b0, w[3:0]} - {1'b0, sb[3:0]} - {4'h0, bi};
        r = d[7:0];
        ov = (w[7] ^ sb[7]) & (w[7] ^ r[7]);
        case (op)
            0, 1: r = {m[6:0], m[7]};
            2, 3: begin
                r = {m[6:0], f[3]};
                ef[3] = m[7];
            end
            4, 5: r = {m[0], m[7:1]};
            6, 7: begin
                r = {f[3], m[7:1]};
                ef[3] = m[0];
            end
            8, 9, 10, 11, 12, 13: ef = {(r == 8'h00) & (op > 5'd10 | f[5]), r[7] ^ ov, ~d[8],
                ~h[4], r == 8'h00, ov};
            14, 15: r = m - 8'h01;
            16, 17: r = m + 8'h01;
            18: r = `RSS_BYTE_ONES;
            19: r = m | (8'h01 << b);
            20: sk = (m != 8'h00);
            21: sk = m[b];
            default: ;
        endcase
        if (op >= 5'd14 && op <= 5'd17) begin
            sk = (r == 8'h00);
        end
        if (op inside {1, 3, 5, 7, 8, 9, 11, 12, 15, 17}) begin
            ew = r;
        end
        if (op inside {0, 2, 4, 6, 10, 13, 14, 16, 18, 19}) begin
            em = r;
            mw = 1'b1;
            lastRes = r;
        end
        w0 = wrCount;
        s0 = skipCount;
        d0 = dummyCount;
        ahb(1'b1, `RSS_OFS_MEMOP, {24'h0, m});
        ahb(1'b1, `RSS_OFS_IMM, {24'h0, im});
        ahb(1'b1, `RSS_OFS_WREG, {24'h0, w});
        ahb(1'b1, `RSS_OFS_FLAGS, {26'h0, f});
        ahb(1'b1, `RSS_OFS_CMD, {21'h0, b, 3'h0, op});
        rd(`RSS_OFS_WREG, {24'h0, ew}, "wreg");
        rd(`RSS_OFS_FLAGS, {26'h0, ef}, "flags");
        rd(`RSS_OFS_MEMOP, {24'h0, em}, "memop");
        rd(`RSS_OFS_MEMRES, {24'h0, lastRes}, "memres");
        if (op < 5'd22) begin
            rd(`RSS_OFS_STATUS, {26'h0, sk ? `RSS_CYC_SKIP : `RSS_CYC_PLAIN, 1'b0, mw, sk, 1'b0},
                "status");
        end
        check("memory writes", 32'(wrCount - w0), {31'h0, mw});
        check("memory byte", {24'h0, memByte}, {24'h0, lastRes});
        check("skips", 32'(skipCount - s0), {31'h0, sk});
        check("dummy cycles", 32'(dummyCount - d0), {31'h0, sk});
    endtask : run_op

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h52DE;
        failures = 0;
        n_compared = 0;
        lastRes = 8'h00;
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rdPend = 1'b0;
        repeat (2) @(posedge clk_sys);
        check("ready in reset", {31'h0, hreadyout}, 32'h1);
        check("outputs in reset", {29'h0, memWrEn, skipNext, dummyCycle}, 32'h0);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(`RSS_OFS_FLAGS, {26'h0, `RSS_FLAGS_RST}, "flags after reset");
        rd(`RSS_OFS_STATUS, {26'h0, `RSS_CYC_PLAIN, 4'h0}, "status after reset");
        rd(8'h1C, 32'h0, "unmapped read");
        ahb(1'b1, `RSS_OFS_WREG, 32'h5A);
        ahb(1'b1, 8'h20, 32'hFF);
        ahb(1'b1, `RSS_OFS_MEMRES, 32'h77);
        rd(`RSS_OFS_WREG, 32'h5A, "wreg after unmapped write");
        rd(`RSS_OFS_MEMRES, 32'h0, "read-only memres");
        $display("test registers done");
        run_op(5'd16, 8'hFF, 8'h00, 8'h11, 6'h00, 3'h0);
        run_op(5'd17, 8'hFF, 8'h00, 8'h11, 6'h3F, 3'h0);
        run_op(5'd14, 8'h01, 8'h00, 8'h22, 6'h15, 3'h0);
        run_op(5'd15, 8'h01, 8'h00, 8'h22, 6'h2A, 3'h0);
        run_op(5'd14, 8'h00, 8'h00, 8'h22, 6'h00, 3'h0);
        run_op(5'd20, 8'h00, 8'h00, 8'h33, 6'h00, 3'h0);
        run_op(5'd21, 8'h7F, 8'h00, 8'h33, 6'h00, 3'h7);
        run_op(5'd21, 8'h80, 8'h00, 8'h33, 6'h00, 3'h7);
        run_op(5'd19, 8'h00, 8'h00, 8'h44, 6'h00, 3'h7);
        run_op(5'd8, 8'h01, 8'h00, 8'h00, 6'h00, 3'h0);
        run_op(5'd12, 8'h00, 8'h80, 8'h7F, 6'h08, 3'h0);
        run_op(5'd10, 8'h00, 8'h00, 8'h00, 6'h28, 3'h0);
        $display("test boundaries done");
        for (i = 0; i < 96; i++) begin
            run_op(5'(i % 32), 8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
                6'($random(seed)), 3'($random(seed)));
        end
        $display("test random done");
        check("dummy pairing", 32'(pairErr), 32'h0);
        conclude();
    end
endmodule : rotate_subtract_skip_alu_tb_top
